// ### lps_pkg.sv
// shared constants and types of the low-power mode sequencer
package lps_pkg;
  // ----------------------------------------------------------------
  // interrupt line map
  // ----------------------------------------------------------------
  localparam int NUM_LINES = 48;
  localparam int IRQ_PM = 22;
  localparam int IRQ_GPIO_FIRST = 26;
  localparam int NUM_GPIO_IRQ = 11;
  localparam int IRQ_BACKUP_PM = 37;
  localparam int IRQ_BACKUP_SYS = 38;
  localparam int IRQ_TMR_FIRST = 39;
  localparam int NUM_TMR_IRQ = 5;
  localparam int IRQ_WDT = 44;
  localparam int IRQ_EXT_FIRST = 45;
  localparam int NUM_EXT_IRQ = 3;
  // lines whose source keeps its clock while the core clocks stop
  localparam logic [NUM_LINES-1:0] ASYNC_LINES = 48'hffe0_0040_0000;
  // ----------------------------------------------------------------
  // wake and reset sources
  // ----------------------------------------------------------------
  localparam int NUM_WAKE = 9;
  localparam int WK_EXT_FIRST = 0;
  localparam int WK_TMR_ALARM = 3;
  localparam int WK_TMR_PER = 4;
  localparam int WK_TMR_OVF = 5;
  localparam int WK_WDT = 6;
  localparam int WK_IO_BOD = 7;
  localparam int WK_CORE_BOD = 8;
  // external interrupt and timer wake without an enable bit
  localparam logic [NUM_WAKE-1:0] WAKE_FREE_MASK = 9'h03f;
  localparam int NUM_RST = 4;
  localparam int RC_IO_BOD = 0;
  localparam int RC_CORE_BOD = 1;
  localparam int RC_WDT = 2;
  localparam int RC_PIN = 3;
  localparam int RC_BACKUP = 4;
  localparam int RC_POR = 5;
  localparam int RC_W = 6;
  localparam logic [RC_W-1:0] RC_RESET_VAL = 6'h20;
  localparam logic [1:0] RUN_MODE_ZERO = 2'h0;
  localparam logic [1:0] DEPTH_STOP_SYNC = 2'h3;
  // ----------------------------------------------------------------
  // register map of the controller
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_AWEN = 8'h08;
  localparam logic [7:0] REG_UNMASK_LO = 8'h0c;
  localparam logic [7:0] REG_UNMASK_HI = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_CAUSE = 8'h18;
  localparam int CTRL_DEPTH = 0;
  localparam int CTRL_HOLD = 2;
  localparam int CTRL_SLOW_SEL = 3;
  localparam int CTRL_WAKE_IRQ = 4;
  localparam int CTRL_AUTO_WAKE = 5;
  localparam int CTRL_RUN_MODE = 8;
  localparam int CMD_SLEEP = 0;
  localparam int CMD_DEEP = 1;
  localparam int CMD_BACKUP = 2;
  localparam int CMD_CLEAR = 3;
  localparam int STAT_RUN_MODE = 4;
  localparam int STAT_WAKE = 8;
  localparam int CAUSE_BACKUP_WAKE = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ST_RUN, ST_SLEEP, ST_WAIT, ST_HOLD, ST_BACKUP, ST_CORE_RST
  } lps_state_type;
endpackage

// ### lps_link_if.sv
// link between the core-side controller and the sequencer
`timescale 1ns/1ns
`default_nettype none
interface lps_link_if;
  import lps_pkg::*;
  logic wfi_req;
  logic [1:0] sleep_depth_select;
  logic deep_sleep_select;
  logic hold_state_select;
  logic backup_select;
  logic slow_clock_source_select;
  logic wake_irq_enable;
  logic [1:0] run_mode;
  logic run_mode_wr;
  logic [NUM_WAKE-1:0] async_wake_enable;
  logic [NUM_LINES-1:0] irq_unmask;
  logic cause_clear;
  lps_state_type mode;
  logic [1:0] active_run_mode;
  logic [NUM_WAKE-1:0] wake_cause;
  logic [NUM_WAKE-1:0] backup_wake_cause;
  logic [RC_W-1:0] reset_cause;

  modport dev_mp (
    input wfi_req, sleep_depth_select, deep_sleep_select, hold_state_select, backup_select,
    input slow_clock_source_select, wake_irq_enable, run_mode, run_mode_wr, async_wake_enable,
    input irq_unmask, cause_clear,
    output mode, active_run_mode, wake_cause, backup_wake_cause, reset_cause
  );
  modport host_mp (
    output wfi_req, sleep_depth_select, deep_sleep_select, hold_state_select, backup_select,
    output slow_clock_source_select, wake_irq_enable, run_mode, run_mode_wr, async_wake_enable,
    output irq_unmask, cause_clear,
    input mode, active_run_mode, wake_cause, backup_wake_cause, reset_cause
  );
endinterface
`default_nettype wire

// ### lps_device.sv
// low-power mode sequencer: mode state, wake and reset handling, cause records
//
// Summary of operation
// - light sleep: selects cleared, depth programmed first
// - light sleep ends on unmasked interrupt
// - unclocked source cannot wake light sleep
// - wait/hold: only enabled slow oscillators run
// - wait/hold keep core domain powered
// - no autonomous peripheral wake in hold
// - wait/hold entry: deep=1, backup=0, choose hold
// - wait/hold woken only by async sources
// - software enables async wakes except external/timer
// - wake raises power manager or peripheral interrupt
// - wait/hold resume previous run mode
// - backup: core off, backup domain, slow clock
// - pin configuration frozen during backup
// - backup entry: deep=1 and backup=1
// - backup ends on reset or enabled wake
// - backup wake sources: ext, bods, timer, watchdog
// - select bit picks rc or crystal slow clock
// - reset exit: supply stable, flag reset cause
// - wake exit: core-only reset, previous run mode
// - wake exit sets backup flag in reset cause
// - fixed interrupt line assignment 22 and 26 to 47
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ns
`default_nettype none
module lps_device (
  input wire logic clk_sys,
  input wire logic rst_n,
  lps_link_if.dev_mp link,
  input wire logic [lps_pkg::NUM_GPIO_IRQ-1:0] gpio_irq,
  input wire logic backup_pm_irq,
  input wire logic backup_sys_irq,
  input wire logic [lps_pkg::NUM_TMR_IRQ-1:0] tmr_irq,
  input wire logic wdt_irq,
  input wire logic [lps_pkg::NUM_EXT_IRQ-1:0] ext_irq,
  input wire logic [lps_pkg::NUM_LINES-1:0] src_clk_run,
  input wire logic [lps_pkg::NUM_WAKE-1:0] wake_evt,
  input wire logic [lps_pkg::NUM_RST-1:0] rst_src,
  input wire logic rc_slow_enable,
  input wire logic xtal_slow_enable,
  input wire logic core_supply_ok,
  output logic [lps_pkg::NUM_LINES-1:0] irq_line,
  output logic cpu_clk_en,
  output logic sync_clk_en,
  output logic rc_slow_run,
  output logic xtal_slow_run,
  output logic slow_clk_sel,
  output logic core_power_on,
  output logic io_hold,
  output logic core_reset_n
);
  import lps_pkg::*;

  lps_state_type state;
  lps_state_type next_state;
  logic [NUM_LINES-1:0] raw_irq;
  logic [NUM_LINES-1:0] next_irq;
  logic [NUM_WAKE-1:0] wake_ok;
  logic [1:0] saved_run_mode;
  logic [1:0] active_run_mode;
  logic [1:0] depth_q;
  logic [NUM_WAKE-1:0] wake_cause;
  logic [NUM_WAKE-1:0] backup_wake_cause;
  logic [RC_W-1:0] reset_cause;
  logic reset_exit;
  logic pm_wake_pulse;
  logic any_rst;
  logic sleep_wake;
  logic deep_wake;
  logic backup_wake;
  logic resume;

  // ----------------------------------------------------------------
  // interrupt lines
  // ----------------------------------------------------------------
  always_comb begin
    raw_irq = '0;
    raw_irq[IRQ_PM] = pm_wake_pulse;
    raw_irq[IRQ_GPIO_FIRST +: NUM_GPIO_IRQ] = gpio_irq;
    raw_irq[IRQ_BACKUP_PM] = backup_pm_irq;
    raw_irq[IRQ_BACKUP_SYS] = backup_sys_irq;
    raw_irq[IRQ_TMR_FIRST +: NUM_TMR_IRQ] = tmr_irq;
    raw_irq[IRQ_WDT] = wdt_irq;
    raw_irq[IRQ_EXT_FIRST +: NUM_EXT_IRQ] = ext_irq;
  end

  // a source whose clock is stopped cannot raise its line, unless the line is one of ASYNC_LINES
  for (genvar g = 0; g < NUM_LINES; g++) begin : g_gate
    assign next_irq[g] = raw_irq[g] & (src_clk_run[g] | ASYNC_LINES[g]);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq_line <= '0;
    end else begin
      irq_line <= next_irq;
    end
  end

  // ----------------------------------------------------------------
  // wake and reset decisions
  // ----------------------------------------------------------------
  assign any_rst = |rst_src;
  assign wake_ok = wake_evt & (link.async_wake_enable | WAKE_FREE_MASK);
  assign sleep_wake = (state == ST_SLEEP) && |(irq_line & link.irq_unmask);
  assign deep_wake = ((state == ST_WAIT) || (state == ST_HOLD)) && |wake_ok;
  assign backup_wake = (state == ST_BACKUP) && |wake_ok;
  assign resume = sleep_wake || deep_wake;

  always_comb begin
    next_state = state;
    if (any_rst) begin
      next_state = ST_CORE_RST;
    end else begin
      case (state)
        ST_RUN: begin
          if (link.wfi_req) begin
            if (!link.deep_sleep_select) begin
              next_state = ST_SLEEP;
            end else if (link.backup_select) begin
              next_state = ST_BACKUP;
            end else if (link.hold_state_select) begin
              next_state = ST_HOLD;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
        ST_SLEEP: begin
          if (sleep_wake) begin
            next_state = ST_RUN;
          end
        end
        ST_WAIT, ST_HOLD: begin
          if (deep_wake) begin
            next_state = ST_RUN;
          end
        end
        ST_BACKUP: begin
          if (backup_wake) begin
            next_state = ST_CORE_RST;
          end
        end
        ST_CORE_RST: begin
          if (core_supply_ok) begin
            next_state = ST_RUN;
          end
        end
        default: next_state = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // run mode bookkeeping
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      saved_run_mode <= RUN_MODE_ZERO;
      active_run_mode <= RUN_MODE_ZERO;
      depth_q <= '0;
      reset_exit <= 1'b1;
    end else begin
      if (state == ST_RUN && link.wfi_req) begin
        saved_run_mode <= active_run_mode;
        depth_q <= link.sleep_depth_select;
      end
      if (any_rst) begin
        reset_exit <= 1'b1;
      end else if (backup_wake) begin
        reset_exit <= 1'b0;
      end
      if (state == ST_CORE_RST && next_state == ST_RUN) begin
        active_run_mode <= reset_exit ? RUN_MODE_ZERO : saved_run_mode;
      end else if (resume) begin
        active_run_mode <= saved_run_mode;
      end else if (state == ST_RUN && link.run_mode_wr) begin
        active_run_mode <= link.run_mode;
      end
    end
  end

  // ----------------------------------------------------------------
  // cause records: a new event wins over a clear in the same cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wake_cause <= '0;
      backup_wake_cause <= '0;
      reset_cause <= RC_RESET_VAL;
      pm_wake_pulse <= 1'b0;
    end else begin
      wake_cause <= (link.cause_clear ? '0 : wake_cause) | (deep_wake ? wake_ok : '0);
      // backup domain record survives the core-only reset
      backup_wake_cause <= (link.cause_clear ? '0 : backup_wake_cause) |
                           (backup_wake ? wake_ok : '0);
      reset_cause <= (link.cause_clear ? '0 : reset_cause) |
                     {1'b0, backup_wake, rst_src};
      pm_wake_pulse <= deep_wake && link.wake_irq_enable;
    end
  end

  // ----------------------------------------------------------------
  // clocks, power and pins
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clk_en <= 1'b1;
      sync_clk_en <= 1'b1;
      rc_slow_run <= 1'b0;
      xtal_slow_run <= 1'b0;
      slow_clk_sel <= 1'b0;
      core_power_on <= 1'b1;
      io_hold <= 1'b0;
      core_reset_n <= 1'b1;
    end else begin
      cpu_clk_en <= (next_state == ST_RUN);
      // deepest light-sleep setting also stops the peripheral clocks
      sync_clk_en <= (next_state == ST_RUN) ||
                     ((next_state == ST_SLEEP) && (depth_q != DEPTH_STOP_SYNC));
      rc_slow_run <= rc_slow_enable;
      xtal_slow_run <= xtal_slow_enable;
      // choice frozen while the core is away
      if (state == ST_RUN) begin
        slow_clk_sel <= link.slow_clock_source_select;
      end
      core_power_on <= (next_state != ST_BACKUP);
      io_hold <= (next_state == ST_BACKUP);
      core_reset_n <= (next_state != ST_CORE_RST);
    end
  end

  assign link.mode = state;
  assign link.active_run_mode = active_run_mode;
  assign link.wake_cause = wake_cause;
  assign link.backup_wake_cause = backup_wake_cause;
  assign link.reset_cause = reset_cause;
endmodule
`default_nettype wire

// ### lps_host.sv
// core-side controller: register slave on AXI4-Lite driving the sequencer link
`timescale 1ns/1ns
`default_nettype none
module lps_host (
  input wire logic clk_sys,
  input wire logic rst_n,
  lps_link_if.host_mp link,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic auto_wake_allow
);
  import lps_pkg::*;

  logic [31:0] ctrl;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic [7:0] awaddr_q;
  logic aw_got;
  logic w_got;
  logic do_write;
  logic wfi_pending;
  logic [31:0] cmd;
  logic [31:0] next_rdata;
  logic rd_hit;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_got && !s_axi_bvalid;
  assign s_axi_wready = !w_got && !s_axi_bvalid;
  assign do_write = aw_got && w_got && !s_axi_bvalid;
  assign cmd = do_write && awaddr_q == REG_CMD ? merge(32'h0, wdata_q, wstrb_q) : 32'h0;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_got <= 1'b0;
      w_got <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got <= 1'b1;
        awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awaddr_q <= REG_UNMASK_HI) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers and entry sequences
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      link.async_wake_enable <= '0;
      link.irq_unmask <= '0;
      link.run_mode_wr <= 1'b0;
    end else begin
      link.run_mode_wr <= do_write && awaddr_q == REG_CTRL;
      if (do_write && awaddr_q == REG_CTRL) begin
        ctrl <= merge(ctrl, wdata_q, wstrb_q);
      end
      if (do_write && awaddr_q == REG_AWEN) begin
        link.async_wake_enable <= NUM_WAKE'(merge(32'(link.async_wake_enable), wdata_q, wstrb_q));
      end
      if (do_write && awaddr_q == REG_UNMASK_LO) begin
        link.irq_unmask[31:0] <= merge(link.irq_unmask[31:0], wdata_q, wstrb_q);
      end
      if (do_write && awaddr_q == REG_UNMASK_HI) begin
        link.irq_unmask[NUM_LINES-1:32] <= 16'(merge(32'(link.irq_unmask[NUM_LINES-1:32]), wdata_q, wstrb_q));
      end
    end
  end

  assign link.sleep_depth_select = ctrl[CTRL_DEPTH +: 2];
  assign link.slow_clock_source_select = ctrl[CTRL_SLOW_SEL];
  assign link.wake_irq_enable = ctrl[CTRL_WAKE_IRQ];
  assign link.run_mode = ctrl[CTRL_RUN_MODE +: 2];

  // selects are settled one cycle before the wait-for-interrupt pulse
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link.deep_sleep_select <= 1'b0;
      link.hold_state_select <= 1'b0;
      link.backup_select <= 1'b0;
      link.wfi_req <= 1'b0;
      link.cause_clear <= 1'b0;
      wfi_pending <= 1'b0;
      auto_wake_allow <= 1'b0;
    end else begin
      link.cause_clear <= cmd[CMD_CLEAR];
      link.wfi_req <= wfi_pending && link.mode == ST_RUN;
      wfi_pending <= |cmd[CMD_BACKUP:CMD_SLEEP];
      if (cmd[CMD_BACKUP]) begin
        link.deep_sleep_select <= 1'b1;
        link.backup_select <= 1'b1;
      end else if (cmd[CMD_DEEP]) begin
        link.deep_sleep_select <= 1'b1;
        link.backup_select <= 1'b0;
        link.hold_state_select <= ctrl[CTRL_HOLD];
      end else if (cmd[CMD_SLEEP]) begin
        link.deep_sleep_select <= 1'b0;
        link.hold_state_select <= 1'b0;
        link.backup_select <= 1'b0;
      end
      auto_wake_allow <= ctrl[CTRL_AUTO_WAKE] &&
                         !(link.deep_sleep_select && link.hold_state_select && !link.backup_select) &&
                         link.mode != ST_HOLD;
    end
  end

  // ----------------------------------------------------------------
  // read channel
  // ----------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    rd_hit = 1'b1;
    case ({s_axi_araddr[7:2], 2'b00})
      REG_CTRL: next_rdata = ctrl;
      REG_AWEN: next_rdata = 32'(link.async_wake_enable);
      REG_UNMASK_LO: next_rdata = link.irq_unmask[31:0];
      REG_UNMASK_HI: next_rdata = 32'(link.irq_unmask[NUM_LINES-1:32]);
      REG_STATUS: begin
        next_rdata[2:0] = link.mode;
        next_rdata[STAT_RUN_MODE +: 2] = link.active_run_mode;
        next_rdata[STAT_WAKE +: NUM_WAKE] = link.wake_cause;
      end
      REG_CAUSE: begin
        next_rdata[RC_W-1:0] = link.reset_cause;
        next_rdata[CAUSE_BACKUP_WAKE +: NUM_WAKE] = link.backup_wake_cause;
      end
      REG_CMD: next_rdata = '0;
      default: rd_hit = 1'b0;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### lps_monitor.sv
// concurrent checks on the link between controller and sequencer
`timescale 1ns/1ns
`default_nettype none
module lps_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wfi_req,
  input wire logic deep_sleep_select,
  input wire logic hold_state_select,
  input wire logic backup_select,
  input wire logic [1:0] run_mode,
  input wire logic run_mode_wr,
  input wire lps_pkg::lps_state_type mode,
  input wire logic [1:0] active_run_mode,
  input wire logic [lps_pkg::NUM_WAKE-1:0] wake_cause,
  input wire logic [lps_pkg::RC_W-1:0] reset_cause
);
  import lps_pkg::*;
  // ----------------------------------------------------------------
  // mode entry, run mode and cause records
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_light_entry: assert property (mode == ST_RUN && wfi_req && !deep_sleep_select |=> mode == ST_SLEEP)
    else $error("light sleep not entered");
  a_wait_entry: assert property (mode == ST_RUN && wfi_req && deep_sleep_select && !backup_select
    && !hold_state_select |=> mode == ST_WAIT) else $error("wait not entered");
  a_hold_entry: assert property (mode == ST_RUN && wfi_req && deep_sleep_select && !backup_select
    && hold_state_select |=> mode == ST_HOLD) else $error("hold not entered");
  a_backup_entry: assert property (mode == ST_RUN && wfi_req && deep_sleep_select && backup_select
    |=> mode == ST_BACKUP) else $error("backup not entered");
  a_run_mode_load: assert property (run_mode_wr && mode == ST_RUN |=> active_run_mode == $past(run_mode))
    else $error("run mode not loaded");
  a_low_keep_mode: assert property (mode inside {ST_WAIT, ST_HOLD} |=> $stable(active_run_mode))
    else $error("run mode lost in wait");
  a_wake_cause_rec: assert property (mode == ST_WAIT ##1 mode == ST_RUN |-> wake_cause != '0)
    else $error("wake cause not recorded");
  a_backup_flag: assert property (mode == ST_BACKUP ##1 mode == ST_CORE_RST
    |-> ##[0:2] (reset_cause[4:0] != 5'h00)) else $error("backup exit not flagged");
  a_reset_start: assert property ($rose(rst_n) |-> mode == ST_RUN && !deep_sleep_select && !backup_select
    && reset_cause == RC_RESET_VAL) else $error("bad state after reset");
  c_sleep_wake: cover property (mode == ST_SLEEP ##1 mode == ST_RUN);
  c_hold_wake: cover property (mode == ST_HOLD ##1 mode == ST_RUN);
  c_core_rst_exit: cover property (mode == ST_CORE_RST ##1 mode == ST_RUN);
endmodule
`default_nettype wire

// ### low_power_mode_sequencer_tb.sv
// self-checking bench for the low-power mode sequencer, both ends
`timescale 1ns/1ns
`default_nettype none
module low_power_mode_sequencer_tb;
  import lps_pkg::*;
  typedef struct {logic [9:0] ctrl; logic [2:0] cmd; logic [8:0] awen; logic [8:0] wk; logic [10:0] gp;
    lps_state_type mid; lps_state_type fin;} lps_row_type;
  lps_row_type rows [7] = '{
    '{10'h000, 3'h1, 9'h000, 9'h000, 11'h001, ST_SLEEP, ST_RUN},
    '{10'h120, 3'h2, 9'h000, 9'h001, 11'h000, ST_WAIT, ST_RUN},
    '{10'h22c, 3'h2, 9'h000, 9'h008, 11'h000, ST_HOLD, ST_RUN},
    '{10'h000, 3'h2, 9'h000, 9'h040, 11'h000, ST_WAIT, ST_WAIT},
    '{10'h000, 3'h0, 9'h000, 9'h020, 11'h000, ST_WAIT, ST_RUN},
    '{10'h000, 3'h2, 9'h040, 9'h040, 11'h000, ST_WAIT, ST_RUN},
    '{10'h300, 3'h4, 9'h000, 9'h010, 11'h000, ST_BACKUP, ST_RUN}};
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf, rst_src = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, io_hold, core_power_on;
  logic cpu_clk_en, sync_clk_en, rc_slow_run, xtal_slow_run, slow_clk_sel, core_reset_n, auto_wake_allow;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic [10:0] gpio_irq = 11'h0;
  logic [4:0] tmr_irq = 5'h0;
  logic [47:0] src_clk_run = '1;
  logic [8:0] wake_evt = 9'h0;
  logic core_supply_ok = 1'b1, rc_slow_enable = 1'b1, xtal_slow_enable = 1'b0;
  int err_count = 0, checked = 0;
  lps_link_if link ();
  lps_host u_lps_host (.clk_sys, .rst_n, .link(link), .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .auto_wake_allow);
  lps_device u_lps_device (.clk_sys, .rst_n, .link(link), .gpio_irq, .backup_pm_irq(1'b0), .backup_sys_irq(1'b0),
    .tmr_irq, .wdt_irq(1'b0), .ext_irq(3'h0), .src_clk_run, .wake_evt, .rst_src, .rc_slow_enable, .xtal_slow_enable,
    .core_supply_ok, .irq_line(), .cpu_clk_en, .sync_clk_en, .rc_slow_run, .xtal_slow_run,
    .slow_clk_sel, .core_power_on, .io_hold, .core_reset_n);
  lps_monitor u_lps_monitor (.clk_sys, .rst_n, .wfi_req(link.wfi_req), .deep_sleep_select(link.deep_sleep_select),
    .hold_state_select(link.hold_state_select), .backup_select(link.backup_select), .run_mode(link.run_mode),
    .run_mode_wr(link.run_mode_wr), .mode(link.mode), .active_run_mode(link.active_run_mode),
    .wake_cause(link.wake_cause), .reset_cause(link.reset_cause));
  always #10 clk_sys = ~clk_sys;
  // ----------------------------------------------------------------
  // bus tasks and comparison
  // ----------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [7:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata; rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    report_and_stop();
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({link.mode, link.reset_cause, link.deep_sleep_select, link.backup_select}, {ST_RUN, RC_RESET_VAL, 2'b0});
    axr(REG_CTRL); chk({rs, rd}, {RESP_OKAY, 32'h0});
    axw(REG_UNMASK_LO, '1);
    axw(REG_UNMASK_HI, 32'h0000ffff);
    for (int i = 0; i < 7; i++) begin
      axw(REG_CTRL, {22'h0, rows[i].ctrl});
      axw(REG_AWEN, {23'h0, rows[i].awen});
      axw(REG_CMD, {28'h0, 1'b1, rows[i].cmd});
      repeat (4) @(posedge clk_sys);
      chk(link.mode, rows[i].mid);
      chk({io_hold, core_power_on}, {rows[i].mid == ST_BACKUP, rows[i].mid != ST_BACKUP});
      chk({cpu_clk_en, sync_clk_en, rc_slow_run, xtal_slow_run}, {1'b0, rows[i].mid == ST_SLEEP, 2'b10});
      chk(slow_clk_sel, rows[i].ctrl[3]);
      chk(auto_wake_allow, rows[i].ctrl[5] && rows[i].mid != ST_HOLD);
      wake_evt <= rows[i].wk; gpio_irq <= rows[i].gp;
      repeat (8) @(posedge clk_sys);
      wake_evt <= 9'h0; gpio_irq <= 11'h0;
      chk(link.mode, rows[i].fin);
      chk((rows[i].mid == ST_BACKUP ? link.backup_wake_cause : link.wake_cause) & rows[i].wk,
        rows[i].fin == ST_RUN ? rows[i].wk : 9'h0);
      if (rows[i].fin == ST_RUN) chk(link.active_run_mode, rows[i].ctrl[9:8]);
    end
    chk(link.reset_cause, 6'h10);
    axr(8'h1c); chk({rs, rd}, {RESP_SLVERR, 32'h0});
    // stopped source clock must not end light sleep
    src_clk_run[26] <= 1'b0;
    axw(REG_CMD, 32'h1);
    gpio_irq <= 11'h001;
    repeat (6) @(posedge clk_sys);
    chk(link.mode, ST_SLEEP);
    tmr_irq <= 5'h01;
    repeat (6) @(posedge clk_sys);
    chk(link.mode, ST_RUN);
    gpio_irq <= 11'h0; tmr_irq <= 5'h0; src_clk_run <= '1;
    // watchdog reset out of backup, supply late
    axw(REG_CTRL, 32'h100);
    axw(REG_CMD, 32'hc);
    repeat (4) @(posedge clk_sys);
    core_supply_ok <= 1'b0; rst_src <= 4'h4;
    repeat (3) @(posedge clk_sys);
    rst_src <= 4'h0;
    repeat (3) @(posedge clk_sys);
    chk({link.mode, core_reset_n}, {ST_CORE_RST, 1'b0});
    core_supply_ok <= 1'b1;
    repeat (4) @(posedge clk_sys);
    chk({link.mode, link.active_run_mode, link.reset_cause}, {ST_RUN, RUN_MODE_ZERO, 6'h04});
    report_and_stop();
  end
endmodule
`default_nettype wire
